// ==== logic/data_space_decoder.sv ====
// data-space address decoder: direct ram, rom window, banked area, registers
`timescale 1ns/1ps
module data_space_decoder (
	// clock and reset
	input  wire logic                       CORE_CLK,
	input  wire logic                       SRST,
	// core request
	input  wire logic                       REQ_RD,
	input  wire logic                       REQ_WR,
	input  wire logic [7:0]                 REQ_ADDR,
	input  wire logic [7:0]                 REQ_WDATA,
	// core answer
	output logic                            CORE_READY,
	output logic                            CORE_DONE,
	output logic                            CORE_ABORT,
	output logic [7:0]                      CORE_RDATA,
	// write data shared by all targets
	output logic                            MEM_WR,
	output logic [7:0]                      MEM_WDATA,
	// data ram
	output logic                            RAM_SEL,
	output logic [7:0]                      RAM_ADDR,
	input  wire logic [7:0]                 RAM_RDATA,
	// eeprom
	input  wire logic                       EE_BUSY,
	output logic                            EE_SEL,
	output logic [8:0]                      EE_ADDR,
	input  wire logic [7:0]                 EE_RDATA,
	// display ram
	output logic                            OSD_SEL,
	output logic                            OSD_CTRL_SEL,
	output logic                            OSD_PAGE,
	output logic [5:0]                      OSD_ADDR,
	input  wire logic [7:0]                 OSD_RDATA,
	// program rom data port
	output logic                            ROM_RD,
	output logic [13:0]                     ROM_ADDR,
	input  wire logic [7:0]                 ROM_RDATA,
	// peripheral registers
	output logic                            REG_SEL,
	output logic                            LATCH_CTRL_SEL,
	output logic                            EE_CTRL_SEL,
	output logic [7:0]                      REG_ADDR,
	input  wire logic [7:0]                 REG_RDATA
);

	data_space_pkg::acc_state_t  state;
	data_space_pkg::acc_state_t  next_state;
	data_space_pkg::target_t     next_target;
	data_space_pkg::target_t     bank_target;
	data_space_pkg::target_t     cap_target;
	logic                        cap_read;
	logic                        cap_abort;
	logic [7:0]                  return_data;

	bank_sel_if sel ();

	// ------------------------------------------------------------------
	// request acceptance
	// ------------------------------------------------------------------
	// a write wins when both strobes come together
	wire logic req_any  = REQ_RD || REQ_WR;
	wire logic take     = CORE_READY && req_any;
	wire logic is_write = REQ_WR;
	wire logic [5:0] offset = REQ_ADDR[data_space_pkg::OFFSET_W-1:0];

	// ------------------------------------------------------------------
	// area decode
	// ------------------------------------------------------------------
	wire logic in_bank   = REQ_ADDR <= data_space_pkg::BANK_AREA_HI;
	wire logic in_window = (REQ_ADDR >= data_space_pkg::WINDOW_LO) &&
		(REQ_ADDR <= data_space_pkg::WINDOW_HI);
	wire logic in_direct = (REQ_ADDR >= data_space_pkg::DIRECT_RAM_LO) &&
		(REQ_ADDR <= data_space_pkg::DIRECT_RAM_HI);
	wire logic hit_window_reg = REQ_ADDR == data_space_pkg::ROM_WINDOW_BASE_ADDR;
	wire logic hit_bank_reg   = REQ_ADDR == data_space_pkg::DATA_BANK_SELECT_ADDR;
	wire logic hit_latch_ctrl = REQ_ADDR == data_space_pkg::LATCH_CTRL_ADDR;
	wire logic hit_ee_ctrl    = REQ_ADDR == data_space_pkg::EEPROM_CTRL_ADDR;

	// eeprom page access while programming runs goes nowhere; the
	// eeprom itself keeps programming since it never sees the strobe
	wire logic ee_blocked = in_bank && (sel.bank_kind == data_space_pkg::TGT_EEPROM) && EE_BUSY;

	assign bank_target = ee_blocked ? data_space_pkg::TGT_NONE : sel.bank_kind;

	// the rom window is read-only; writes there are dropped
	wire logic rom_ok = sel.window_valid && !is_write;

	// the two selection registers live here, so they never strobe a target
	assign next_target = (hit_window_reg || hit_bank_reg) ? data_space_pkg::TGT_LOCAL :
		in_bank   ? bank_target :
		in_window ? (rom_ok ? data_space_pkg::TGT_ROM : data_space_pkg::TGT_NONE) :
		in_direct ? data_space_pkg::TGT_RAM : data_space_pkg::TGT_REG;

	wire logic writable = (next_target == data_space_pkg::TGT_RAM) ||
		(next_target == data_space_pkg::TGT_EEPROM) ||
		(next_target == data_space_pkg::TGT_OSD) ||
		(next_target == data_space_pkg::TGT_REG);

	// ------------------------------------------------------------------
	// address forming per target
	// ------------------------------------------------------------------
	// window base sits above the six offset bits: 8 + 6 bits cap the reach at 16K
	wire logic [13:0] next_rom_addr = {sel.window_base, offset};

	// slot 0 is the direct ram, banked ram pages follow in slots 1 to 3
	wire logic [1:0] ram_slot = in_direct ? data_space_pkg::RAM_DIRECT_SLOT : sel.bank_page[1:0];
	wire logic [7:0] next_ram_addr = {ram_slot, offset};

	// page times 64 plus offset across six pages gives 384 bytes
	wire logic [8:0] next_ee_addr = {sel.bank_page, offset};

	// control registers decode only on display page 6
	wire logic next_osd_page = sel.bank_page[0];
	wire logic osd_ctrl_hit = (next_osd_page == data_space_pkg::OSD_PAGE6) &&
		(offset >= data_space_pkg::OSD_CTRL_LO) &&
		(offset <= data_space_pkg::OSD_CTRL_HI);

	// ------------------------------------------------------------------
	// selection registers
	// ------------------------------------------------------------------
	// written on the taking edge; the next request is taken three edges later,
	// so every later access sees the new value
	wire logic write_window = take && is_write && hit_window_reg;
	wire logic write_bank   = take && is_write && hit_bank_reg;

	select_regs regs (
		.clk          (CORE_CLK),
		.srst         (SRST),
		.write_window (write_window),
		.write_bank   (write_bank),
		.wdata        (REQ_WDATA),
		.sel          (sel)
	);

	// ------------------------------------------------------------------
	// access sequencing
	// ------------------------------------------------------------------
	// a fixed three-cycle path; no target can stretch an access
	always_comb begin
		case (state)
			data_space_pkg::ACC_IDLE: begin
				next_state = take ? data_space_pkg::ACC_STROBE : data_space_pkg::ACC_IDLE;
			end
			data_space_pkg::ACC_STROBE: begin
				next_state = data_space_pkg::ACC_CAPTURE;
			end
			data_space_pkg::ACC_CAPTURE: begin
				next_state = data_space_pkg::ACC_IDLE;
			end
			default: begin
				next_state = data_space_pkg::ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			state <= data_space_pkg::ACC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	wire logic capturing = state == data_space_pkg::ACC_CAPTURE;

	// one select per target, qualified by the take so a refused request leaves no trace
	wire logic go_ram      = take && (next_target == data_space_pkg::TGT_RAM);
	wire logic go_ee       = take && (next_target == data_space_pkg::TGT_EEPROM);
	wire logic go_osd      = take && (next_target == data_space_pkg::TGT_OSD);
	wire logic go_osd_ctrl = go_osd && osd_ctrl_hit;
	wire logic go_rom      = take && (next_target == data_space_pkg::TGT_ROM);
	wire logic go_reg      = take && (next_target == data_space_pkg::TGT_REG);
	wire logic go_latch    = take && hit_latch_ctrl;
	wire logic go_ee_ctrl  = take && hit_ee_ctrl;
	wire logic go_wr       = take && is_write && writable;

	// remember what the access was until its answer is captured
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			cap_target <= data_space_pkg::TGT_NONE;
			cap_read   <= 1'b0;
			cap_abort  <= 1'b0;
		end else if (take) begin
			cap_target <= next_target;
			cap_read   <= !is_write;
			cap_abort  <= ee_blocked;
		end
	end

	// ------------------------------------------------------------------
	// one-cycle target strobes
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			RAM_SEL        <= 1'b0;
			EE_SEL         <= 1'b0;
			OSD_SEL        <= 1'b0;
			OSD_CTRL_SEL   <= 1'b0;
			ROM_RD         <= 1'b0;
			REG_SEL        <= 1'b0;
			LATCH_CTRL_SEL <= 1'b0;
			EE_CTRL_SEL    <= 1'b0;
			MEM_WR         <= 1'b0;
		end else begin
			RAM_SEL        <= go_ram;
			EE_SEL         <= go_ee;
			OSD_SEL        <= go_osd;
			OSD_CTRL_SEL   <= go_osd_ctrl;
			ROM_RD         <= go_rom;
			REG_SEL        <= go_reg;
			LATCH_CTRL_SEL <= go_latch;
			EE_CTRL_SEL    <= go_ee_ctrl;
			MEM_WR         <= go_wr;
		end
	end

	// ------------------------------------------------------------------
	// addresses and write data, held until the next access
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			MEM_WDATA <= 8'h00;
			REG_ADDR  <= 8'h00;
		end else if (take) begin
			// a refused request never moves them
			MEM_WDATA <= REQ_WDATA;
			REG_ADDR  <= REQ_ADDR;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			RAM_ADDR <= 8'h00;
			EE_ADDR  <= 9'h000;
			OSD_PAGE <= 1'b0;
			OSD_ADDR <= 6'h00;
			ROM_ADDR <= 14'h0000;
		end else if (take) begin
			RAM_ADDR <= next_ram_addr;
			EE_ADDR  <= next_ee_addr;
			OSD_PAGE <= next_osd_page;
			OSD_ADDR <= offset;
			ROM_ADDR <= next_rom_addr;
		end
	end

	// ------------------------------------------------------------------
	// read data return
	// ------------------------------------------------------------------
	// targets answer one cycle after their strobe; registers of the
	// selection pair are write-only and read back as the idle value
	always_comb begin
		case (cap_target)
			data_space_pkg::TGT_RAM: begin
				return_data = RAM_RDATA;
			end
			data_space_pkg::TGT_EEPROM: begin
				return_data = EE_RDATA;
			end
			data_space_pkg::TGT_OSD: begin
				return_data = OSD_RDATA;
			end
			data_space_pkg::TGT_ROM: begin
				return_data = ROM_RDATA;
			end
			data_space_pkg::TGT_REG: begin
				return_data = REG_RDATA;
			end
			default: begin
				return_data = data_space_pkg::RDATA_NONE;
			end
		endcase
	end

	// writes answer the idle value so stale read data never looks fresh
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			CORE_RDATA <= data_space_pkg::RDATA_NONE;
		end else if (capturing) begin
			CORE_RDATA <= cap_read ? return_data : data_space_pkg::RDATA_NONE;
		end
	end

	// ------------------------------------------------------------------
	// handshake towards the core
	// ------------------------------------------------------------------
	// one access in flight keeps the return path a plain mux, at the
	// price of a request every three cycles at best
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			CORE_READY <= 1'b1;
			CORE_DONE  <= 1'b0;
			CORE_ABORT <= 1'b0;
		end else begin
			CORE_DONE  <= capturing;
			CORE_ABORT <= capturing && cap_abort;
			// ready drops on the take itself, so later requests are ignored until done
			if (take) begin
				CORE_READY <= 1'b0;
			end else if (capturing) begin
				CORE_READY <= 1'b1;
			end
		end
	end

endmodule // data_space_decoder

// ==== logic/data_space_pkg.sv ====
// shared constants and types of the data-space decoder
package data_space_pkg;

	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 8;
	localparam int OFFSET_W   = 6;
	localparam int ROM_ADDR_W = 14;
	localparam int EE_ADDR_W  = 9;

	// data-space areas
	localparam logic [7:0] BANK_AREA_HI   = 8'h3F;
	localparam logic [7:0] WINDOW_LO      = 8'h40;
	localparam logic [7:0] WINDOW_HI      = 8'h7F;
	localparam logic [7:0] DIRECT_RAM_LO  = 8'h80;
	localparam logic [7:0] DIRECT_RAM_HI  = 8'hBF;

	// fixed register addresses
	localparam logic [7:0] ROM_WINDOW_BASE_ADDR  = 8'hC9;
	localparam logic [7:0] DATA_BANK_SELECT_ADDR = 8'hE8;
	localparam logic [7:0] LATCH_CTRL_ADDR       = 8'hE9;
	localparam logic [7:0] EEPROM_CTRL_ADDR      = 8'hEA;

	// display control window inside display page 6
	localparam logic [5:0] OSD_CTRL_LO = 6'h10;
	localparam logic [5:0] OSD_CTRL_HI = 6'h17;

	// bank register field positions
	localparam int BANK_EE_HIGH_BIT = 7;
	localparam int BANK_OSD6_BIT    = 6;
	localparam int BANK_OSD5_BIT    = 5;
	localparam int BANK_RAM4_BIT    = 4;
	localparam int BANK_RAM3_BIT    = 3;
	localparam int BANK_RAM2_BIT    = 2;

	// page numbering towards the memories
	localparam logic [2:0] EE_HIGH_PAGE_BASE = 3'h3;
	localparam logic [1:0] RAM_DIRECT_SLOT   = 2'h0;
	localparam logic [1:0] RAM_PAGE2_SLOT    = 2'h1;
	localparam logic [1:0] RAM_PAGE3_SLOT    = 2'h2;
	localparam logic [1:0] RAM_PAGE4_SLOT    = 2'h3;
	localparam logic       OSD_PAGE5         = 1'b0;
	localparam logic       OSD_PAGE6         = 1'b1;

	// read answer when nothing drives the data
	localparam logic [7:0] RDATA_NONE = 8'h00;

	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_RAM,
		TGT_EEPROM,
		TGT_OSD,
		TGT_ROM,
		TGT_REG,
		TGT_LOCAL
	} target_t;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_STROBE,
		ACC_CAPTURE
	} acc_state_t;

endpackage

// ==== logic/bank_sel_if.sv ====
// selection state passed from the register holder to the decoder
`timescale 1ns/1ps
interface bank_sel_if;
	logic [7:0]                  window_base;
	logic                        window_valid;
	data_space_pkg::target_t     bank_kind;
	logic [2:0]                  bank_page;

	modport owner (output window_base, output window_valid, output bank_kind, output bank_page);
	modport user  (input window_base, input window_valid, input bank_kind, input bank_page);
endinterface

// ==== logic/select_regs.sv ====
// write-only window and bank registers with bank decode
`timescale 1ns/1ps
module select_regs (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// register writes
	input  wire logic        write_window,
	input  wire logic        write_bank,
	input  wire logic [7:0]  wdata,
	// decoded selection
	bank_sel_if.owner        sel
);
	logic [7:0] window_base;
	logic [7:0] bank;
	logic       window_valid;
	logic       bank_valid;

	// contents are not reset: software must write them before use
	always_ff @(posedge clk) begin
		if (write_window) begin
			window_base <= wdata;
		end
		if (write_bank) begin
			bank <= wdata;
		end
	end

	// only the written-yet flags are reset so unwritten contents never steer a strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			window_valid <= 1'b0;
			bank_valid   <= 1'b0;
		end else begin
			window_valid <= window_valid | write_window;
			bank_valid   <= bank_valid | write_bank;
		end
	end

	wire logic [1:0] ee_low  = bank[1:0];
	wire logic       ee_hit  = |ee_low;
	wire logic [2:0] ee_base = bank[data_space_pkg::BANK_EE_HIGH_BIT] ? data_space_pkg::EE_HIGH_PAGE_BASE : 3'h0;
	wire logic [2:0] ee_page = ee_base + {1'b0, ee_low} - 3'h1;

	wire logic       ram2    = bank[data_space_pkg::BANK_RAM2_BIT];
	wire logic       ram3    = bank[data_space_pkg::BANK_RAM3_BIT];
	wire logic       ram4    = bank[data_space_pkg::BANK_RAM4_BIT];
	wire logic       ram_hit = ram2 | ram3 | ram4;
	wire logic [1:0] ram_slot = ram2 ? data_space_pkg::RAM_PAGE2_SLOT :
		ram3 ? data_space_pkg::RAM_PAGE3_SLOT : data_space_pkg::RAM_PAGE4_SLOT;

	wire logic       osd5    = bank[data_space_pkg::BANK_OSD5_BIT];
	wire logic       osd6    = bank[data_space_pkg::BANK_OSD6_BIT];
	wire logic       osd_hit = osd5 | osd6;
	wire logic       osd_page = osd5 ? data_space_pkg::OSD_PAGE5 : data_space_pkg::OSD_PAGE6;

	// with several choices set, eeprom wins over ram, ram over display
	assign sel.bank_kind = !bank_valid ? data_space_pkg::TGT_NONE :
		ee_hit ? data_space_pkg::TGT_EEPROM :
		ram_hit ? data_space_pkg::TGT_RAM :
		osd_hit ? data_space_pkg::TGT_OSD : data_space_pkg::TGT_NONE;
	assign sel.bank_page = ee_hit ? ee_page : ram_hit ? {1'b0, ram_slot} : {2'b00, osd_page};
	assign sel.window_base  = window_base;
	assign sel.window_valid = window_valid;

endmodule // select_regs

// ==== test/data_space_monitor.sv ====
// assertion checker bound to the data-space decoder ports
`timescale 1ns/1ps
module data_space_monitor (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        SRST,
	// core side
	input wire logic        REQ_RD,
	input wire logic        REQ_WR,
	input wire logic [7:0]  REQ_ADDR,
	input wire logic        CORE_READY,
	input wire logic        CORE_DONE,
	input wire logic        CORE_ABORT,
	// target side
	input wire logic        EE_BUSY,
	input wire logic        EE_SEL,
	input wire logic        RAM_SEL,
	input wire logic [7:0]  RAM_ADDR,
	input wire logic        OSD_SEL,
	input wire logic        OSD_CTRL_SEL,
	input wire logic        OSD_PAGE,
	input wire logic [5:0]  OSD_ADDR,
	input wire logic        ROM_RD,
	input wire logic [13:0] ROM_ADDR,
	input wire logic        REG_SEL,
	input wire logic        LATCH_CTRL_SEL
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	wire take = CORE_READY && (REQ_RD || REQ_WR);
	wire any_sel = RAM_SEL || EE_SEL || OSD_SEL || ROM_RD || REG_SEL;

	a_access_timing: assert property (take |=> !CORE_READY [*2] ##1 (CORE_READY && CORE_DONE))
		else $error("access timing wrong");
	a_abort_done: assert property (CORE_ABORT |-> CORE_DONE)
		else $error("abort without done");
	a_busy_blocks: assert property (EE_SEL |-> !$past(EE_BUSY))
		else $error("eeprom strobed while busy");
	a_window_read: assert property (ROM_RD |-> $past(REQ_ADDR[7:6]) == 2'h1 && !$past(REQ_WR))
		else $error("rom read outside window");
	a_window_offset: assert property (ROM_RD |-> ROM_ADDR[5:0] == $past(REQ_ADDR[5:0]))
		else $error("rom offset wrong");
	a_window_nowrite: assert property (take && REQ_WR && REQ_ADDR[7:6] == 2'h1 |=> !any_sel)
		else $error("window write reached a target");
	a_direct_ram: assert property (take && REQ_ADDR[7:6] == 2'h2 |=> RAM_SEL && RAM_ADDR == {2'h0, $past(REQ_ADDR[5:0])})
		else $error("direct ram decode wrong");
	a_ctrl_page: assert property (OSD_CTRL_SEL |-> OSD_SEL && OSD_PAGE && OSD_ADDR[5:3] == 3'h2)
		else $error("display control outside page 6");
	a_latch_decode: assert property (take && REQ_ADDR == 8'hE9 |=> REG_SEL && LATCH_CTRL_SEL)
		else $error("latch control not decoded");
	a_bank_only: assert property (EE_SEL |-> $past(REQ_ADDR[7:6]) == 2'h0)
		else $error("eeprom outside bank area");
endmodule // data_space_monitor

bind data_space_decoder data_space_monitor u_mon (.CORE_CLK, .SRST, .REQ_RD, .REQ_WR, .REQ_ADDR, .CORE_READY,
	.CORE_DONE, .CORE_ABORT, .EE_BUSY, .EE_SEL, .RAM_SEL, .RAM_ADDR, .OSD_SEL, .OSD_CTRL_SEL, .OSD_PAGE,
	.OSD_ADDR, .ROM_RD, .ROM_ADDR, .REG_SEL, .LATCH_CTRL_SEL);

// ==== test/data_space_mem_model.sv ====
// memories and registers answering the decoder strobes
`timescale 1ns/1ps
module data_space_mem_model (
	// clock
	input wire logic        clk,
	// strobes and addresses
	input wire logic        ram_sel,
	input wire logic [7:0]  ram_addr,
	input wire logic        ee_sel,
	input wire logic [8:0]  ee_addr,
	input wire logic        osd_sel,
	input wire logic        osd_page,
	input wire logic [5:0]  osd_addr,
	input wire logic        rom_rd,
	input wire logic [13:0] rom_addr,
	input wire logic        reg_sel,
	input wire logic [7:0]  reg_addr,
	// read data
	output logic [7:0]      ram_rdata,
	output logic [7:0]      ee_rdata,
	output logic [7:0]      osd_rdata,
	output logic [7:0]      rom_rdata,
	output logic [7:0]      reg_rdata
);
	initial {ram_rdata, ee_rdata, osd_rdata, rom_rdata, reg_rdata} = 40'h0;
	// data is valid only the cycle after a strobe; it toggles otherwise so a late sample shows
	always @(posedge clk) begin
		ram_rdata <= ram_sel ? ram_addr ^ 8'h5A : ~ram_rdata;
		ee_rdata  <= ee_sel ? ee_addr[7:0] ^ {ee_addr[8], 7'h3C} : ~ee_rdata;
		osd_rdata <= osd_sel ? {osd_page, 1'b0, osd_addr} : ~osd_rdata;
		rom_rdata <= rom_rd ? rom_addr[7:0] ^ rom_addr[13:6] : ~rom_rdata;
		reg_rdata <= reg_sel ? ~reg_addr : ~reg_rdata;
	end
endmodule // data_space_mem_model

// ==== test/data_space_decoder_tb_top.sv ====
// self-checking testbench for the data-space decoder
`timescale 1ns/1ps
module data_space_decoder_tb_top;
	logic        CORE_CLK, SRST, REQ_RD, REQ_WR, EE_BUSY, CORE_READY, CORE_DONE, CORE_ABORT, MEM_WR;
	logic        RAM_SEL, EE_SEL, OSD_SEL, OSD_CTRL_SEL, OSD_PAGE, ROM_RD, REG_SEL, LATCH_CTRL_SEL, EE_CTRL_SEL;
	logic [7:0]  REQ_ADDR, REQ_WDATA, CORE_RDATA, MEM_WDATA, RAM_ADDR, REG_ADDR;
	logic [7:0]  RAM_RDATA, EE_RDATA, OSD_RDATA, ROM_RDATA, REG_RDATA;
	logic [8:0]  EE_ADDR;
	logic [5:0]  OSD_ADDR;
	logic [13:0] ROM_ADDR;
	logic [8:0]  sv;
	logic        ab;
	int          err_count = 0;
	int          samples_checked = 0;
	localparam logic [8:0] S_RAM = 9'h100, S_EE = 9'h080, S_OSD = 9'h040, S_OCT = 9'h020, S_ROM = 9'h010;
	localparam logic [8:0] S_REG = 9'h008, S_LAT = 9'h004, S_EEC = 9'h002, S_WR = 9'h001;

	data_space_decoder uut (.CORE_CLK, .SRST, .REQ_RD, .REQ_WR, .REQ_ADDR, .REQ_WDATA, .CORE_READY, .CORE_DONE,
		.CORE_ABORT, .CORE_RDATA, .MEM_WR, .MEM_WDATA, .RAM_SEL, .RAM_ADDR, .RAM_RDATA, .EE_BUSY, .EE_SEL,
		.EE_ADDR, .EE_RDATA, .OSD_SEL, .OSD_CTRL_SEL, .OSD_PAGE, .OSD_ADDR, .OSD_RDATA, .ROM_RD, .ROM_ADDR,
		.ROM_RDATA, .REG_SEL, .LATCH_CTRL_SEL, .EE_CTRL_SEL, .REG_ADDR, .REG_RDATA);
	data_space_mem_model mem (.clk(CORE_CLK), .ram_sel(RAM_SEL), .ram_addr(RAM_ADDR), .ee_sel(EE_SEL),
		.ee_addr(EE_ADDR), .osd_sel(OSD_SEL), .osd_page(OSD_PAGE), .osd_addr(OSD_ADDR), .rom_rd(ROM_RD),
		.rom_addr(ROM_ADDR), .reg_sel(REG_SEL), .reg_addr(REG_ADDR), .ram_rdata(RAM_RDATA),
		.ee_rdata(EE_RDATA), .osd_rdata(OSD_RDATA), .rom_rdata(ROM_RDATA), .reg_rdata(REG_RDATA));

	initial begin
		CORE_CLK = 1'b0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	function automatic logic [7:0] rom_pat(input logic [13:0] r);
		return r[7:0] ^ r[13:6];
	endfunction

	task automatic final_report;
		$display("mismatches %0d comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one access at a fixed four-cycle rate; strobes captured in the cycle after the take
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		REQ_RD <= !w;
		REQ_WR <= w;
		REQ_ADDR <= a;
		REQ_WDATA <= d;
		@(posedge CORE_CLK);
		REQ_RD <= 1'b0;
		REQ_WR <= 1'b0;
		#1;
		sv = {RAM_SEL, EE_SEL, OSD_SEL, OSD_CTRL_SEL, ROM_RD, REG_SEL, LATCH_CTRL_SEL, EE_CTRL_SEL, MEM_WR};
		chk(CORE_READY, 16'h0, "ready during access");
		repeat (2) @(posedge CORE_CLK);
		#1;
		ab = CORE_ABORT;
		chk({CORE_READY, CORE_DONE}, 16'h3, "done");
	endtask

	task automatic rd(input logic [7:0] a, input logic [8:0] es, input logic [7:0] ed);
		acc(1'b0, a, 8'h00);
		chk(sv, es, "read strobes");
		chk(CORE_RDATA, ed, "read data");
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [8:0] es);
		acc(1'b1, a, d);
		chk(sv, es, "write strobes");
		chk(CORE_RDATA, 16'h0, "write answer");
		if (es != 9'h000) chk(MEM_WDATA, d, "write data");
	endtask

	task automatic t_unwritten;
		rd(8'h40, 9'h000, 8'h00);
		rd(8'h00, 9'h000, 8'h00);
	endtask

	task automatic t_window;
		wr(8'h90, 8'h28, S_RAM | S_WR); // ram image first
		wr(8'hC9, 8'h28, 9'h000);
		rd(8'h59, S_ROM, rom_pat(14'h0A19));
		chk(ROM_ADDR, 14'h0A19, "rom address");
		wr(8'h45, 8'h77, 9'h000);
		rd(8'hC9, 9'h000, 8'h00);
		wr(8'hC9, 8'hFF, 9'h000);
		rd(8'h7F, S_ROM, rom_pat(14'h3FFF));
		chk(ROM_ADDR, 14'h3FFF, "rom top");
		wr(8'hC9, 8'h01, 9'h000);
		rd(8'h40, S_ROM, rom_pat(14'h0040));
	endtask

	task automatic t_direct;
		rd(8'h80, S_RAM, 8'h5A);
		rd(8'hBF, S_RAM, 8'h3F ^ 8'h5A);
		wr(8'h85, 8'hC3, S_RAM | S_WR);
		chk(RAM_ADDR, 8'h05, "ram address");
	endtask

	task automatic t_banks;
		logic [7:0] v [11] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
		logic [8:0] e;
		logic [7:0] r;
		for (int i = 0; i < 11; i++) begin
			wr(8'hE8, v[i], 9'h000); // one choice only
			if (i < 6) begin
				e = 9'(i * 64 + 42);
				rd(8'h2A, S_EE, e[7:0] ^ {e[8], 7'h3C});
				chk(EE_ADDR, e, "eeprom address");
			end else if (i < 9) begin
				r = {2'(i - 5), 6'h2A};
				rd(8'h2A, S_RAM, r ^ 8'h5A);
				chk(RAM_ADDR, r, "ram page address");
			end else begin
				rd(8'h2A, S_OSD, {i == 10, 7'h2A});
			end
		end
	endtask

	task automatic t_osd_ctrl;
		wr(8'hE8, 8'h40, 9'h000);
		rd(8'h10, S_OSD | S_OCT, 8'h90);
		rd(8'h17, S_OSD | S_OCT, 8'h97);
		rd(8'h18, S_OSD, 8'h98);
		wr(8'h12, 8'hA5, S_OSD | S_OCT | S_WR);
		wr(8'hE8, 8'h20, 9'h000);
		rd(8'h10, S_OSD, 8'h10);
	endtask

	task automatic t_regs;
		rd(8'hE9, S_REG | S_LAT, 8'h16);
		rd(8'hEA, S_REG | S_EEC, 8'h15);
		rd(8'hC0, S_REG, 8'h3F);
		chk(REG_ADDR, 8'hC0, "register address");
		rd(8'hE8, 9'h000, 8'h00);
		wr(8'hE8, 8'h80, 9'h000); // high eeprom bit alone
		rd(8'h2A, 9'h000, 8'h00);
	endtask

	task automatic t_busy;
		wr(8'hE8, 8'h83, 9'h000);
		@(posedge CORE_CLK);
		EE_BUSY <= 1'b1;
		rd(8'h05, 9'h000, 8'h00);
		chk(ab, 16'h1, "abort");
		rd(8'h81, S_RAM, 8'h01 ^ 8'h5A);
		chk(ab, 16'h0, "no abort on ram");
		@(posedge CORE_CLK);
		EE_BUSY <= 1'b0;
		rd(8'h05, S_EE, 8'h45 ^ 8'hBC);
		chk(EE_ADDR, 9'h145, "eeprom page 5");
	endtask

	initial begin
		repeat (4000) @(posedge CORE_CLK);
		err_count++;
		final_report;
	end

	initial begin
		SRST = 1'b1;
		{REQ_RD, REQ_WR, EE_BUSY} = 3'h0;
		REQ_ADDR = 8'h00;
		REQ_WDATA = 8'h00;
		repeat (10) @(posedge CORE_CLK);
		SRST <= 1'b0;
		@(posedge CORE_CLK);
		#1;
		chk(CORE_READY, 16'h1, "ready after reset");
		t_unwritten;
		t_window;
		t_direct;
		t_banks;
		t_osd_ctrl;
		t_regs;
		t_busy;
		final_report;
	end
endmodule // data_space_decoder_tb_top
